// ==== logic/imd_datapath.sv ====
`timescale 1ns/1ns
`include "imd_defines.svh"

// Execute-stage integer datapath.
module imd_datapath
	import imd_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	input  imd_req_t         req,
	output logic             stall,
	output logic             res_valid,
	output imd_res_t         res,
	output logic [31:0]      y,
	output logic             tag_trap
);

	imd_icc_t    icc;          // Architectural condition codes.
	imd_icc_t    next_icc;
	logic [31:0] next_y;
	imd_res_t    next_res;
	logic        next_res_valid;
	logic        next_tag_trap;
	logic        take;         // A request is accepted this cycle.
	logic        is_mul;       // Request is a full multiply.
	logic        mul_zero;     // Multiply with a zero operand.
	logic        mul_busy;
	logic        mul_done;
	logic [63:0] mul_prod;
	logic        mul_scc;      // Pending multiply updates cc.
	logic        next_mul_scc;

	// Multiply requests with two nonzero operands hold decode until the product is ready.
	assign stall = mul_busy;
	assign take = req_valid && !mul_busy;
	assign is_mul = (req.op == IMD_OP_UMUL) || (req.op == IMD_OP_SMUL);
	assign mul_zero = (req.a == 32'h0) || (req.b == 32'h0);

	imd_mult u_mult (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.start     (take && is_mul && !mul_zero),
		.signed_op (req.op == IMD_OP_SMUL),
		.a         (req.a),
		.b         (req.b),
		.busy      (mul_busy),
		.done      (mul_done),
		.product   (mul_prod)
	);

	// Index of the highest set bit, or the no-find code.
	function automatic logic [31:0] scan_msb(input logic [31:0] w);
		logic [31:0] r;
		r = `IMD_SCAN_NONE;
		for (int i = 0; i < 32; i++) begin
			if (w[i]) begin
				r = 32'(i);
			end
		end
		return r;
	endfunction

	// Negative and zero flags of a result word.
	function automatic logic [1:0] nz(input logic [31:0] w);
		return {w[31], (w == 32'h0)};
	endfunction

	// Operation decode and evaluation.
	always_comb begin
		logic [32:0] sum;     // Adder output with carry.
		logic [31:0] opb;     // Adder second operand after inversion.
		logic [31:0] opa;     // Adder first operand.
		logic        cin;     // Adder carry in.
		logic        is_sub;  // Adder subtracts.
		logic        ovf;     // Signed overflow of the adder.
		logic        cc_en;   // This operation writes the condition codes.
		logic [32:0] dsh;     // Divide step shifted remainder.
		logic [32:0] ddif;    // Divide step trial difference.
		sum = 33'h0;
		opb = 32'h0;
		opa = req.a;
		cin = 1'b0;
		is_sub = 1'b0;
		ovf = 1'b0;
		cc_en = req.set_cc;
		dsh = {req.a, y[31]};
		ddif = dsh - {1'b0, req.b};
		next_icc = icc;
		next_y = y;
		next_res = res;
		next_res_valid = 1'b0;
		next_tag_trap = 1'b0;
		next_mul_scc = mul_scc;
		// Shared adder set-up.
		is_sub = (req.op == IMD_OP_SUB) || (req.op == IMD_OP_SUBX) ||
			(req.op == IMD_OP_TSUB) || (req.op == IMD_OP_TSUBT);
		if (req.op == IMD_OP_ADDX) begin
			cin = icc.c;
		end else if (req.op == IMD_OP_SUBX) begin
			cin = !icc.c;
		end else begin
			cin = is_sub;
		end
		if (req.op == IMD_OP_MSTEP) begin
			// Multiply step: shift in N^V, add the multiplicand on y[0].
			opa = {icc.n ^ icc.v, req.a[31:1]};
			opb = y[0] ? req.b : 32'h0;
		end else begin
			opb = is_sub ? ~req.b : req.b;
		end
		sum = {1'b0, opa} + {1'b0, opb} + {32'h0, cin};
		ovf = (opa[31] == opb[31]) && (sum[31] != opa[31]);
		if (mul_done) begin
			// Product finishes; high word goes to y.
			next_res.value = mul_prod[31:0];
			next_y = mul_prod[63:32];
			next_res_valid = 1'b1;
			if (mul_scc) begin
				next_icc = {nz(mul_prod[31:0]), 2'b00};
			end
		end else if (take) begin
			next_res_valid = !is_mul || mul_zero;
			next_res.value = 32'h0;
			case (req.op)
				IMD_OP_AND:  next_res.value = req.a & req.b;
				IMD_OP_OR:   next_res.value = req.a | req.b;
				IMD_OP_XOR:  next_res.value = req.a ^ req.b;
				IMD_OP_ANDN: next_res.value = req.a & ~req.b;
				IMD_OP_ORN:  next_res.value = req.a | ~req.b;
				IMD_OP_XNOR: next_res.value = ~(req.a ^ req.b);
				IMD_OP_SLL: begin
					next_res.value = req.a << req.b[4:0];
					cc_en = 1'b0;
				end
				IMD_OP_SRL: begin
					next_res.value = req.a >> req.b[4:0];
					cc_en = 1'b0;
				end
				IMD_OP_SRA: begin
					// Sign bit fills the vacated high positions.
					next_res.value = 32'($signed(req.a) >>> req.b[4:0]);
					cc_en = 1'b0;
				end
				IMD_OP_ADD, IMD_OP_SUB, IMD_OP_ADDX, IMD_OP_SUBX: begin
					next_res.value = sum[31:0];
					if (cc_en) begin
						next_icc = {nz(sum[31:0]), ovf, sum[32] ^ is_sub};
					end
				end
				IMD_OP_TADD, IMD_OP_TSUB, IMD_OP_TADDT, IMD_OP_TSUBT: begin
					// Tag bits set in either operand count as overflow.
					ovf = ovf || (req.a[1:0] != 2'b00) || (req.b[1:0] != 2'b00);
					next_res.value = sum[31:0];
					next_icc = {nz(sum[31:0]), ovf, sum[32] ^ is_sub};
					next_tag_trap = ovf && ((req.op == IMD_OP_TADDT) ||
						(req.op == IMD_OP_TSUBT));
				end
				IMD_OP_UMUL, IMD_OP_SMUL: begin
					// A zero operand skips the multiplier entirely.
					next_mul_scc = req.set_cc;
					if (mul_zero) begin
						next_y = 32'h0;
						if (req.set_cc) begin
							next_icc = {2'b01, 2'b00};
						end
					end
				end
				IMD_OP_MSTEP: begin
					next_res.value = sum[31:0];
					next_y = {req.a[0], y[31:1]};
					next_icc = {nz(sum[31:0]), ovf, sum[32]};
				end
				IMD_OP_DSTEP: begin
					// Restoring step; quotient bit enters y from the right.
					next_res.value = ddif[32] ? dsh[31:0] : ddif[31:0];
					next_y = {y[30:0], !ddif[32]};
					next_icc = {nz(next_res.value), 1'b0, !ddif[32]};
				end
				IMD_OP_SCAN1: begin
					next_res.value = scan_msb(req.a);
					cc_en = 1'b0;
				end
				IMD_OP_SCAN0: begin
					next_res.value = scan_msb(~req.a);
					cc_en = 1'b0;
				end
				IMD_OP_LUI: begin
					next_res.value = req.b << `IMD_LUI_SHIFT;
					cc_en = 1'b0;
				end
				default: begin
					next_res_valid = 1'b0;
					cc_en = 1'b0;
				end
			endcase
			// Logic operations clear V and C when they write cc.
			if (cc_en && (req.op <= IMD_OP_XNOR)) begin
				next_icc = {nz(next_res.value), 2'b00};
			end
		end
		next_res.icc = next_icc;
	end

	// Result and state registers.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			icc <= `IMD_ICC_RST;
			y <= `IMD_Y_RST;
			res <= '0;
			res_valid <= 1'b0;
			tag_trap <= 1'b0;
			mul_scc <= 1'b0;
		end else begin
			icc <= next_icc;
			y <= next_y;
			res <= next_res;
			res_valid <= next_res_valid;
			tag_trap <= next_tag_trap;
			mul_scc <= next_mul_scc;
		end
	end

endmodule

// ==== logic/imd_defines.svh ====
`ifndef IMD_DEFINES_SVH
`define IMD_DEFINES_SVH

// Reset values of the architectural state held in the datapath.
`define IMD_ICC_RST   4'h0
`define IMD_Y_RST     32'h0000_0000

// Condition code field positions inside a packed icc word.
`define IMD_ICC_N     3
`define IMD_ICC_Z     2
`define IMD_ICC_V     1
`define IMD_ICC_C     0

// Multiply latency in clock cycles by multiplicand width.
`define IMD_MUL_CYC_32  5
`define IMD_MUL_CYC_16  3
`define IMD_MUL_CYC_8   2
`define IMD_MUL_CYC_0   1

// Multiplicand bits consumed per multiplier iteration.
`define IMD_MUL_STEP  8

// Scan answer when no bit of the wanted value exists in the word.
`define IMD_SCAN_NONE 32'h0000_003F

// Shift of the immediate in a load_upper_immediate operation.
`define IMD_LUI_SHIFT 10

`endif

// ==== logic/imd_pkg.sv ====
package imd_pkg;

	// Operation codes presented by the decode stage.
	typedef enum logic [4:0] {
		IMD_OP_AND   = 5'h00,
		IMD_OP_OR    = 5'h01,
		IMD_OP_XOR   = 5'h02,
		IMD_OP_ANDN  = 5'h03,
		IMD_OP_ORN   = 5'h04,
		IMD_OP_XNOR  = 5'h05,
		IMD_OP_ADD   = 5'h06,
		IMD_OP_SUB   = 5'h07,
		IMD_OP_ADDX  = 5'h08,
		IMD_OP_SUBX  = 5'h09,
		IMD_OP_TADD  = 5'h0A,
		IMD_OP_TSUB  = 5'h0B,
		IMD_OP_TADDT = 5'h0C,
		IMD_OP_TSUBT = 5'h0D,
		IMD_OP_SLL   = 5'h0E,
		IMD_OP_SRL   = 5'h0F,
		IMD_OP_SRA   = 5'h10,
		IMD_OP_UMUL  = 5'h11,
		IMD_OP_SMUL  = 5'h12,
		IMD_OP_MSTEP = 5'h13,
		IMD_OP_DSTEP = 5'h14,
		IMD_OP_SCAN1 = 5'h15,
		IMD_OP_SCAN0 = 5'h16,
		IMD_OP_LUI   = 5'h17
	} imd_op_t;

	// Condition codes: negative, zero, overflow, carry.
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} imd_icc_t;

	// One request from the decode stage.
	typedef struct packed {
		imd_op_t     op;
		logic [31:0] a;
		logic [31:0] b;
		logic        set_cc;
	} imd_req_t;

	// One result toward the register file.
	typedef struct packed {
		logic [31:0] value;
		imd_icc_t    icc;
	} imd_res_t;

	// Multiplier states, one-hot.
	typedef enum logic [1:0] {
		IMD_M_IDLE = 2'b01,
		IMD_M_RUN  = 2'b10
	} imd_mstate_t;

endpackage

// ==== logic/imd_mult.sv ====
`timescale 1ns/1ns
`include "imd_defines.svh"

// Iterative multiplier: one 8-bit slice of the multiplicand per cycle.
module imd_mult
	import imd_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        start,
	input  wire logic        signed_op,
	input  wire logic [31:0] a,
	input  wire logic [31:0] b,
	output logic             busy,
	output logic             done,
	output logic [63:0]      product
);

	imd_mstate_t state;      // Current multiplier state.
	imd_mstate_t next_state;
	logic [63:0] a_sh;       // Multiplier magnitude, shifted one slice per step.
	logic [63:0] next_a_sh;
	logic [31:0] b_mag;      // Remaining multiplicand magnitude slices.
	logic [31:0] next_b_mag;
	logic [63:0] acc;        // Partial product sum.
	logic [63:0] next_acc;
	logic [1:0]  left;       // Slices still to process after this one.
	logic [1:0]  next_left;
	logic        neg;        // Final product must be negated.
	logic        next_neg;
	logic [31:0] a_abs;      // Operand magnitudes at start.
	logic [31:0] b_abs;
	logic [63:0] sum;        // Accumulator plus this slice.

	// Magnitudes keep the slice count small for short negative operands.
	assign a_abs = (signed_op && a[31]) ? (~a + 32'h1) : a;
	assign b_abs = (signed_op && b[31]) ? (~b + 32'h1) : b;
	assign sum = acc + a_sh * {56'h0, b_mag[7:0]};
	assign busy = (state == IMD_M_RUN);
	assign done = busy && (left == 2'h0);
	assign product = neg ? (~sum + 64'h1) : sum;

	// Next-state logic; slice count is picked from the multiplicand width.
	always_comb begin
		next_state = state;
		next_a_sh = a_sh;
		next_b_mag = b_mag;
		next_acc = acc;
		next_left = left;
		next_neg = neg;
		case (state)
			IMD_M_IDLE: begin
				if (start) begin
					next_state = IMD_M_RUN;
					next_a_sh = {32'h0, a_abs};
					next_b_mag = b_abs;
					next_acc = 64'h0;
					next_neg = signed_op && (a[31] ^ b[31]);
					// Four slices for 32 bits, two for 16, one for 8.
					if (b_abs[31:16] != 16'h0) begin
						next_left = 2'h3;
					end else if (b_abs[15:8] != 8'h0) begin
						next_left = 2'h1;
					end else begin
						next_left = 2'h0;
					end
				end
			end
			IMD_M_RUN: begin
				next_acc = sum;
				next_a_sh = a_sh << `IMD_MUL_STEP;
				next_b_mag = b_mag >> `IMD_MUL_STEP;
				next_left = left - 2'h1;
				if (left == 2'h0) begin
					next_state = IMD_M_IDLE;
				end
			end
			default: begin
				next_state = IMD_M_IDLE;
			end
		endcase
	end

	// State registers only.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= IMD_M_IDLE;
			a_sh <= 64'h0;
			b_mag <= 32'h0;
			acc <= 64'h0;
			left <= 2'h0;
			neg <= 1'b0;
		end else begin
			state <= next_state;
			a_sh <= next_a_sh;
			b_mag <= next_b_mag;
			acc <= next_acc;
			left <= next_left;
			neg <= next_neg;
		end
	end

endmodule

// ==== tb/imd_decode_model.sv ====
`timescale 1ns/1ns
// Decode-stage stand-in that presents a request and holds it while stalled.
module imd_decode_model
	import imd_pkg::*;
(
	input  wire logic     ref_clk,
	input  wire logic     nrst,
	input  wire logic     stall,
	input  wire logic     issue,
	input  wire imd_req_t nreq,
	output logic          req_valid,
	output imd_req_t      req
);
	logic     next_req_valid; // Valid level for the next cycle.
	imd_req_t next_req;       // Request word for the next cycle.

	// An idle bus shows the inverse of its last word, so stale operands never match.
	always_comb begin
		next_req_valid = req_valid;
		next_req = req;
		if (!stall) begin
			next_req_valid = issue;
			next_req = issue ? nreq : ~req;
		end
	end

	// Registers the request.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			req_valid <= 1'b0;
			req <= '0;
		end else begin
			req_valid <= next_req_valid;
			req <= next_req;
		end
	end
endmodule

// ==== tb/imd_monitor.sv ====
`timescale 1ns/1ns
// Watches the datapath ports for latency, stall and result relations.
module imd_monitor
	import imd_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        req_valid,
	input wire imd_req_t    req,
	input wire logic        stall,
	input wire logic        res_valid,
	input wire imd_res_t    res,
	input wire logic [31:0] y,
	input wire logic        tag_trap
);
	wire take = req_valid && !stall; // A request is taken.
	wire mul = req.op inside {IMD_OP_UMUL, IMD_OP_SMUL}; // A multiply.
	wire umul = take && req.op == IMD_OP_UMUL && |req.a && |req.b; // Timed.

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	chk_mul_wide: assert property (umul && |req.b[31:16] |=>
		stall [*4] ##1 (res_valid && !stall)) else $error("wide multiply time");
	chk_mul_half: assert property (umul && !(|req.b[31:16]) && |req.b[15:8] |=>
		stall [*2] ##1 (res_valid && !stall)) else $error("half multiply time");
	chk_mul_byte: assert property (umul && !(|req.b[31:8]) |=>
		stall ##1 (res_valid && !stall)) else $error("byte multiply time");
	chk_mul_zero: assert property (take && mul && !(|req.a && |req.b) |=>
		res_valid && !stall && res.value == '0 && y == '0) else $error("zero multiply");
	chk_scan_none: assert property (take && req.op == IMD_OP_SCAN1 && req.a == '0
		|=> res_valid && res.value == 32'h3F) else $error("empty scan");
	chk_sra_sign: assert property (take && req.op == IMD_OP_SRA |=>
		res.value[31] == $past(req.a[31])) else $error("sign not copied");
	chk_cc_keep: assert property (take && req.op <= IMD_OP_XNOR && !req.set_cc
		|=> $stable(res.icc)) else $error("logic op moved cc");
	chk_trap_pair: assert property (tag_trap |->
		res_valid && res.icc.v) else $error("trap without overflow");
	chk_stall_quiet: assert property (stall |->
		!res_valid) else $error("result while stalled");

	cover property (umul && |req.b[31:16]);
	cover property (tag_trap);
	cover property (req_valid && stall);
endmodule

// ==== tb/integer_multiply_scan_datapath_tb.sv ====
`timescale 1ns/1ns
// Self-checking bench for the execute datapath.
module integer_multiply_scan_datapath_tb
	import imd_pkg::*;
;
	typedef struct {
		imd_op_t     op;
		logic [31:0] a, b;
		logic        c;
		logic [31:0] v;
		logic [3:0]  f, l;
	} imd_row_t;

	logic     ref_clk, nrst, issue, req_valid, stall, res_valid, tag_trap;
	imd_req_t nreq, req;
	imd_res_t res;
	logic [31:0] y;
	int       fail_count = 0;
	int       comparisons = 0;
	int       cycles = 0;
	int       n;

	// Later rows lean on the flags left by earlier ones, so order matters.
	imd_row_t rows [29] = '{
		'{IMD_OP_AND, 32'hF0F0, 32'hFF00, 1'h0, 32'hF000, 4'h0, 4'h1},
		'{IMD_OP_OR, 32'hF0, 32'hF, 1'h0, 32'hFF, 4'h0, 4'h1},
		'{IMD_OP_XOR, 32'hFF, 32'hFF, 1'h1, 32'h0, 4'h4, 4'h1},
		'{IMD_OP_ANDN, 32'hFF, 32'hF, 1'h0, 32'hF0, 4'h4, 4'h1},
		'{IMD_OP_ORN, 32'h0, 32'h0, 1'h1, 32'hFFFFFFFF, 4'h8, 4'h1},
		'{IMD_OP_XNOR, 32'h0, 32'hFFFFFFFF, 1'h0, 32'h0, 4'h8, 4'h1},
		'{IMD_OP_SLL, 32'h1, 32'h1F, 1'h0, 32'h80000000, 4'h8, 4'h1},
		'{IMD_OP_SRL, 32'h80000000, 32'h4, 1'h0, 32'h8000000, 4'h8, 4'h1},
		'{IMD_OP_SRA, 32'h80000000, 32'h4, 1'h0, 32'hF8000000, 4'h8, 4'h1},
		'{IMD_OP_SCAN1, 32'h10000, 32'h0, 1'h0, 32'h10, 4'h8, 4'h1},
		'{IMD_OP_SCAN0, 32'hFFFF7FFF, 32'h0, 1'h0, 32'hF, 4'h8, 4'h1},
		'{IMD_OP_SCAN1, 32'h0, 32'h0, 1'h0, 32'h3F, 4'h8, 4'h1},
		'{IMD_OP_LUI, 32'h0, 32'h3FFFFF, 1'h0, 32'hFFFFFC00, 4'h8, 4'h1},
		'{IMD_OP_UMUL, 32'h3, 32'h100, 1'h0, 32'h300, 4'h8, 4'h3},
		'{IMD_OP_UMUL, 32'h2, 32'h10000, 1'h0, 32'h20000, 4'h8, 4'h5},
		'{IMD_OP_UMUL, 32'h5, 32'h7, 1'h0, 32'h23, 4'h8, 4'h2},
		'{IMD_OP_UMUL, 32'h5, 32'h0, 1'h1, 32'h0, 4'h4, 4'h1},
		'{IMD_OP_SMUL, 32'h3, 32'hFFFFFFFE, 1'h1, 32'hFFFFFFFA, 4'h8, 4'h2},
		'{IMD_OP_ADD, 32'h7FFFFFFF, 32'h1, 1'h1, 32'h80000000, 4'hA, 4'h1},
		'{IMD_OP_SUB, 32'h0, 32'h1, 1'h1, 32'hFFFFFFFF, 4'h9, 4'h1},
		'{IMD_OP_ADDX, 32'h1, 32'h1, 1'h0, 32'h3, 4'h9, 4'h1},
		'{IMD_OP_SUBX, 32'h5, 32'h1, 1'h1, 32'h3, 4'h0, 4'h1},
		'{IMD_OP_TADD, 32'h1, 32'h0, 1'h0, 32'h1, 4'h2, 4'h1},
		'{IMD_OP_TSUB, 32'h8, 32'h4, 1'h0, 32'h4, 4'h0, 4'h1},
		'{IMD_OP_TADDT, 32'h1, 32'h0, 1'h0, 32'h1, 4'h2, 4'h1},
		'{IMD_OP_TSUBT, 32'h8, 32'h4, 1'h0, 32'h4, 4'h0, 4'h1},
		'{IMD_OP_MSTEP, 32'h4, 32'h10, 1'h1, 32'h12, 4'h0, 4'h1},
		'{IMD_OP_DSTEP, 32'h5, 32'h3, 1'h1, 32'h7, 4'h1, 4'h1},
		'{IMD_OP_DSTEP, 32'h1, 32'h5, 1'h1, 32'h3, 4'h0, 4'h1}};

	imd_decode_model u_imd_decode_model (.ref_clk(ref_clk), .nrst(nrst), .stall(stall),
		.issue(issue), .nreq(nreq), .req_valid(req_valid), .req(req));
	imd_datapath u_imd_datapath (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
		.req(req), .stall(stall), .res_valid(res_valid), .res(res), .y(y),
		.tag_trap(tag_trap));

	// Free-running clock.
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Counts a comparison and reports a mismatch.
	task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Issues one request and counts edges until its result shows.
	task automatic send(input imd_req_t r, output int e);
		@(posedge ref_clk);
		issue <= 1'b1;
		nreq <= r;
		@(posedge ref_clk);
		issue <= 1'b0;
		e = 0;
		do begin
			@(posedge ref_clk);
			e++;
			#1;
		end while (!res_valid && e < 12);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Cuts a hang short; the tests need under two hundred cycles.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			wrap_up();
		end
	end

	initial begin
		nrst = 1'b0;
		issue = 1'b0;
		nreq = '0;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			send('{rows[i].op, rows[i].a, rows[i].b, rows[i].c}, n);
			check_value(n, rows[i].l);
			check_value(res.value, rows[i].v);
			check_value(res.icc, rows[i].f);
			check_value(tag_trap, rows[i].op == IMD_OP_TADDT);
			if (rows[i].op inside {IMD_OP_UMUL, IMD_OP_SMUL})
				check_value(y, {32{rows[i].op == IMD_OP_SMUL}});
		end
		// The step rows shift y right once, then left twice with quotient bits one and zero.
		check_value(y, 32'hFFFFFFFE);
		$display("table rows done");
		// An add queued behind a long multiply must wait, then follow it.
		send('{IMD_OP_UMUL, 32'h2, 32'h10000, 1'b0}, n);
		@(posedge ref_clk);
		issue <= 1'b1;
		nreq <= '{IMD_OP_UMUL, 32'h2, 32'h10000, 1'b0};
		@(posedge ref_clk);
		nreq <= '{IMD_OP_ADD, 32'h1, 32'h2, 1'b0};
		@(posedge ref_clk);
		issue <= 1'b0;
		n = 0;
		repeat (10) begin
			@(posedge ref_clk);
			#1;
			if (res_valid === 1'b1)
				n += (n == 0 && res.value === 32'h20000) || (n == 1 && res.value === 32'h3);
		end
		check_value(n, 32'h2);
		$display("stall hold done");
		// A reset in mid-multiply drops the stall and the outputs.
		@(posedge ref_clk);
		issue <= 1'b1;
		nreq <= '{IMD_OP_SMUL, 32'h7, 32'h10000, 1'b1};
		@(posedge ref_clk);
		issue <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b0;
		#1;
		check_value({stall, res_valid, tag_trap}, 32'h0);
		check_value(y | res.value, 32'h0);
		@(posedge ref_clk);
		nrst <= 1'b1;
		send('{IMD_OP_ADD, 32'h1, 32'h2, 1'b0}, n);
		check_value(n, 32'h1);
		check_value(res.value, 32'h3);
		$display("mid-run reset done");
		wrap_up();
	end
endmodule

bind imd_datapath imd_monitor u_imd_monitor (.ref_clk(ref_clk), .nrst(nrst),
	.req_valid(req_valid), .req(req), .stall(stall), .res_valid(res_valid),
	.res(res), .y(y), .tag_trap(tag_trap));
